// ==== hdl/clock_source_select_and_debug_clock_output_pin.sv ====
// Clock source selection and debug clock output control with Wishbone registers
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: Select low: oscillator feeds generator, reference ignored
// RULE_02: Select high: reference feeds generator, oscillator RTC
// RULE_03: Output driven only while clock-off bit clear
// RULE_04: Output enabled after reset until boot sets bit
// RULE_05: Tap select field picks observed internal clock
// RULE_06: Boot with reference bypasses PLL, assumed frequencies
// RULE_07: Boot serial clocks 500 kHz and 400 kHz
// RULE_08: Select strap held fixed during operation
// RULE_09: Reference runs when select high, grounded otherwise
// RULE_10: Slew control register sets output edge rate
module clock_source_select_and_debug_clock_output_pin (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [clk_ctrl_pkg::DATA_W-1:0] wb_dat_i,
    output logic      [clk_ctrl_pkg::DATA_W-1:0] wb_dat_o,
    input  wire logic                          wb_we_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    output logic                               wb_ack_o,
    output logic                               wb_err_o,
    input  wire logic                          clock_select_pin,
    input  wire logic                          external_reference_clock_input,
    input  wire logic                          rtc_osc_clk,
    input  wire logic                          sys_clk_tap,
    input  wire logic                          pll_clk_tap,
    input  wire logic                          boot_start,
    input  wire logic [1:0]                    ref_freq_code,
    output logic                               generator_clk_src,
    output logic                               rtc_timer_clk,
    output logic                               debug_clock_output_pin,
    output logic                               debug_clock_output_oe_n,
    output logic      [15:0]                   output_slew_rate,
    output logic                               pll_bypass,
    output logic      [15:0]                   spi_clk_div,
    output logic      [15:0]                   i2c_clk_div
);
    import clk_ctrl_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] sel_sync_q;                                        // Strap synchroniser
    logic [1:0] sel_sync_d;
    logic [1:0] ref_sync_q;                                        // Reference clock sampler
    logic [1:0] ref_sync_d;
    logic [1:0] rtc_sync_q;                                        // Oscillator sampler
    logic [1:0] rtc_sync_d;
    logic [1:0] sys_sync_q;                                        // System tap sampler
    logic [1:0] sys_sync_d;
    logic [1:0] pll_sync_q;                                        // Generator tap sampler
    logic [1:0] pll_sync_d;
    logic [1:0] boot_sync_q;                                       // Boot start sampler
    logic [1:0] boot_sync_d;

    // Shift each pin through two stages
    always_comb begin
        sel_sync_d  = {sel_sync_q[0], clock_select_pin};
        ref_sync_d  = {ref_sync_q[0], external_reference_clock_input};
        rtc_sync_d  = {rtc_sync_q[0], rtc_osc_clk};
        sys_sync_d  = {sys_sync_q[0], sys_clk_tap};
        pll_sync_d  = {pll_sync_q[0], pll_clk_tap};
        boot_sync_d = {boot_sync_q[0], boot_start};
    end

    // Register synchroniser stages
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sel_sync_q  <= 2'h0;
            ref_sync_q  <= 2'h0;
            rtc_sync_q  <= 2'h0;
            sys_sync_q  <= 2'h0;
            pll_sync_q  <= 2'h0;
            boot_sync_q <= 2'h0;
        end else begin
            sel_sync_q  <= sel_sync_d;
            ref_sync_q  <= ref_sync_d;
            rtc_sync_q  <= rtc_sync_d;
            sys_sync_q  <= sys_sync_d;
            pll_sync_q  <= pll_sync_d;
            boot_sync_q <= boot_sync_d;
        end
    end

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Serial divider for a reference in Hz and a target in Hz, rounded up
    function automatic logic [15:0] serial_div(input int ref_hz, input int tgt_hz);
        int q;
        q = (ref_hz + tgt_hz - 1) / tgt_hz;
        return q[15:0];
    endfunction

    // Reference frequency in Hz from the strap code
    function automatic int ref_hz_of(input logic [1:0] code);
        int r;
        r = REF_B_HZ;
        if (code == 2'h0) begin
            r = REF_A_HZ;
        end else if (code == 2'h2) begin
            r = REF_C_HZ;
        end
        return r;
    endfunction

    // ************************************************************
    // Control state
    // ************************************************************
    logic                   strap_q;                               // Strap latched at the third edge after reset release
    logic                   strap_d;
    logic [1:0]             strap_wait_q;                          // Edges since release, strap taken at third
    logic [1:0]             strap_wait_d;
    logic [15:0]            slew_q;                                // Slew control register
    logic [15:0]            slew_d;
    logic [TAP_W-1:0]       tap_q;                                 // Tap select field
    logic [TAP_W-1:0]       tap_d;
    logic [15:0]            status3_q;                             // Status word three
    logic [15:0]            status3_d;
    logic                   booted_q;                              // Boot sequence has begun
    logic                   booted_d;
    logic                   bypass_q;                              // PLL bypass from boot
    logic                   bypass_d;
    logic [1:0]             ref_code_q;                            // Assumed reference code
    logic [1:0]             ref_code_d;
    logic [15:0]            spi_div_q;                             // Serial peripheral divider
    logic [15:0]            spi_div_d;
    logic [15:0]            i2c_div_q;                             // Two-wire divider
    logic [15:0]            i2c_div_d;
    logic                   ack_q;                                 // Bus acknowledge
    logic                   ack_d;
    logic                   err_q;                                 // Bus error for unmapped
    logic                   err_d;
    logic [DATA_W-1:0]      rdata_q;                               // Bus read data
    logic [DATA_W-1:0]      rdata_d;
    logic                   gen_q;                                 // Generator source clock
    logic                   gen_d;
    logic                   rtc_q;                                 // Timer clock
    logic                   rtc_d;
    logic                   dbg_q;                                 // Debug output level
    logic                   dbg_d;
    logic                   oe_n_q;                                // Debug output enable, low drives
    logic                   oe_n_d;

    logic                   req;                                   // New bus request
    logic                   hit;                                   // Address is mapped
    logic                   sel_ref;                               // Reference currently chosen
    logic [DATA_W-1:0]      rd_mux;                                // Read data source

    // Next-state logic for registers, boot and clock routing
    always_comb begin
        strap_d       = strap_q;
        strap_wait_d  = (strap_wait_q == 2'h3) ? strap_wait_q : strap_wait_q + 2'h1;
        slew_d        = slew_q;
        tap_d         = tap_q;
        status3_d     = status3_q;
        booted_d      = booted_q;
        bypass_d      = bypass_q;
        ref_code_d    = ref_code_q;
        spi_div_d     = spi_div_q;
        i2c_div_d     = i2c_div_q;
        req           = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
        hit           = (wb_adr_i == SLEW_ADDR) || (wb_adr_i == SRC_ADDR) ||
                        (wb_adr_i == STATUS3_ADDR) || (wb_adr_i == BOOT_ADDR);
        ack_d         = req && hit;
        err_d         = req && !hit;
        rd_mux        = '0;

        // Strap captured once, after the synchroniser has filled; later changes are not followed
        if (strap_wait_q == 2'h2) begin
            strap_d = sel_sync_q[1];
        end
        sel_ref = strap_q;

        // Boot start: bypass PLL when reference strapped, set serial clocks and turn output off
        if (boot_sync_q[1] && !booted_q) begin
            booted_d  = 1'b1;
            // RULE_04 boot disables output
            status3_d[CLOCK_OUTPUT_DISABLE_BIT_BIT] = 1'b1;
            // RULE_06 bypass with reference
            bypass_d   = sel_ref;
            ref_code_d = sel_ref ? ref_freq_code : 2'h1;
            // RULE_07 serial boot rates
            spi_div_d  = serial_div(ref_hz_of(sel_ref ? ref_freq_code : 2'h1), SPI_BOOT_HZ);
            i2c_div_d  = serial_div(ref_hz_of(sel_ref ? ref_freq_code : 2'h1), I2C_BOOT_HZ);
        end

        // Register reads
        unique case (wb_adr_i)
            SLEW_ADDR:    rd_mux = {16'h0000, slew_q};
            SRC_ADDR:     rd_mux = {30'h0, tap_q};
            STATUS3_ADDR: rd_mux = {16'h0000, status3_q};
            BOOT_ADDR:    rd_mux = {27'h0, booted_q, ref_code_q, strap_q, bypass_q};
            default:      rd_mux = '0;
        endcase
        rdata_d = (req && !wb_we_i) ? rd_mux : '0;

        // Register writes, low byte lanes only
        if (req && wb_we_i) begin
            // RULE_10 slew register write
            if (wb_adr_i == SLEW_ADDR) begin
                if (wb_sel_i[0]) slew_d[7:0]  = wb_dat_i[7:0];
                if (wb_sel_i[1]) slew_d[15:8] = wb_dat_i[15:8];
            end
            if (wb_adr_i == SRC_ADDR && wb_sel_i[0]) begin
                tap_d = wb_dat_i[TAP_W-1:0];
            end
            if (wb_adr_i == STATUS3_ADDR) begin
                if (wb_sel_i[0]) status3_d[7:0]  = wb_dat_i[7:0];
                if (wb_sel_i[1]) status3_d[15:8] = wb_dat_i[15:8];
            end
        end

        // RULE_01 oscillator drives generator
        // RULE_02 reference drives generator
        gen_d = sel_ref ? ref_sync_q[1] : rtc_sync_q[1];
        rtc_d = rtc_sync_q[1];

        // RULE_05 tap routing
        unique case (tap_sel_t'(tap_q))
            TAP_SYS: dbg_d = sys_sync_q[1];
            TAP_REF: dbg_d = gen_q;
            TAP_RTC: dbg_d = rtc_sync_q[1];
            TAP_PLL: dbg_d = pll_sync_q[1];
        endcase

        // RULE_03 high impedance when off
        oe_n_d = status3_q[CLOCK_OUTPUT_DISABLE_BIT_BIT];
    end

    // Register all control and output state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_q       <= 1'b0;
            strap_wait_q  <= 2'h0;
            slew_q        <= SLEW_RESET;
            tap_q         <= TAP_RESET;
            status3_q     <= STATUS3_RESET;
            booted_q      <= 1'b0;
            bypass_q      <= 1'b0;
            ref_code_q    <= 2'h0;
            spi_div_q     <= 16'h0000;
            i2c_div_q     <= 16'h0000;
            ack_q         <= 1'b0;
            err_q         <= 1'b0;
            rdata_q       <= '0;
            gen_q         <= 1'b0;
            rtc_q         <= 1'b0;
            dbg_q         <= 1'b0;
            oe_n_q        <= 1'b0;
        end else begin
            strap_q       <= strap_d;
            strap_wait_q  <= strap_wait_d;
            slew_q        <= slew_d;
            tap_q         <= tap_d;
            status3_q     <= status3_d;
            booted_q      <= booted_d;
            bypass_q      <= bypass_d;
            ref_code_q    <= ref_code_d;
            spi_div_q     <= spi_div_d;
            i2c_div_q     <= i2c_div_d;
            ack_q         <= ack_d;
            err_q         <= err_d;
            rdata_q       <= rdata_d;
            gen_q         <= gen_d;
            rtc_q         <= rtc_d;
            dbg_q         <= dbg_d;
            oe_n_q        <= oe_n_d;
        end
    end

    // ************************************************************
    // Outputs straight from flip-flops
    // ************************************************************
    assign wb_dat_o                = rdata_q;
    assign wb_ack_o                = ack_q;
    assign wb_err_o                = err_q;
    assign generator_clk_src       = gen_q;
    assign rtc_timer_clk           = rtc_q;
    assign debug_clock_output_pin  = dbg_q;
    assign debug_clock_output_oe_n = oe_n_q;
    assign output_slew_rate        = slew_q;
    assign pll_bypass              = bypass_q;
    assign spi_clk_div             = spi_div_q;
    assign i2c_clk_div             = i2c_div_q;

endmodule

// ==== include/clk_ctrl_pkg.sv ====
// Package of constants for the clock source select and debug clock output block
package clk_ctrl_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int          ADDR_W            = 16;                // Wishbone byte address width
    localparam int          DATA_W            = 32;                // Wishbone data width

    // ************************************************************
    // Register byte addresses (printed offsets are not all word aligned)
    // ************************************************************
    localparam logic [15:0] SLEW_INDEX        = 16'h1c16;          // Printed slew register offset
    localparam logic [15:0] SLEW_ADDR         = 16'h7058;          // Byte address, four times index
    localparam logic [15:0] SRC_ADDR          = 16'h7060;          // Clock output source register
    localparam logic [15:0] STATUS3_ADDR      = 16'h7064;          // Status word three (clock-off bit)
    localparam logic [15:0] BOOT_ADDR         = 16'h7068;          // Boot configuration and status

    // ************************************************************
    // Field positions and widths
    // ************************************************************
    localparam int          CLOCK_OUTPUT_DISABLE_BIT_BIT        = 2;                 // Clock output disable bit in status word
    localparam int          TAP_W             = 2;                 // Width of tap select field
    localparam int          BOOT_BYPASS_BIT   = 0;                 // Boot: PLL bypass in effect
    localparam int          BOOT_SEL_BIT      = 1;                 // Boot: strapped source select
    localparam int          BOOT_REF_LSB      = 2;                 // Boot: reference frequency code
    localparam int          BOOT_DONE_BIT     = 4;                 // Boot: boot has begun

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] SLEW_RESET        = 16'h0000;          // Fast edges after reset
    localparam logic [TAP_W-1:0] TAP_RESET    = 2'h0;              // System clock tap after reset
    localparam logic [15:0] STATUS3_RESET     = 16'h0000;          // Clock output enabled after reset

    // ************************************************************
    // Serial clock targets at boot, in Hz, and reference choices
    // ************************************************************
    localparam int          SPI_BOOT_HZ       = 500000;            // Serial peripheral clock at boot
    localparam int          I2C_BOOT_HZ       = 400000;            // Two-wire clock at boot
    localparam int          REF_A_HZ          = 11289600;          // 11.2896 MHz
    localparam int          REF_B_HZ          = 12000000;          // 12 MHz
    localparam int          REF_C_HZ          = 12288000;          // 12.288 MHz

    // ************************************************************
    // Tap selection codes for the debug output
    // ************************************************************
    typedef enum logic [TAP_W-1:0] {
        TAP_SYS  = 2'b00,                                          // System clock
        TAP_REF  = 2'b01,                                          // Selected generator source, reference or oscillator
        TAP_RTC  = 2'b10,                                          // 32-kHz oscillator
        TAP_PLL  = 2'b11                                           // Generator output
    } tap_sel_t;

endpackage

// ==== tb/clk_ctrl_properties.sv ====
// Checker of bus answers, clock routing and boot outputs
`timescale 1ns/1ns
module clk_ctrl_checker (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [15:0] wb_adr_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        clock_select_pin,
    input wire logic        external_reference_clock_input,
    input wire logic        rtc_osc_clk,
    input wire logic        generator_clk_src,
    input wire logic        rtc_timer_clk,
    input wire logic        debug_clock_output_oe_n,
    input wire logic [15:0] output_slew_rate,
    input wire logic        pll_bypass,
    input wire logic [15:0] spi_clk_div,
    input wire logic [15:0] i2c_clk_div
);
    import clk_ctrl_pkg::*;
    logic [2:0] run_q;   // Edges since reset, saturating
    logic [2:0] run_d;   // Next value of the settle count
    logic       req;     // Request taken at this edge
    logic       mapped;  // Address hits a register
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign mapped = wb_adr_i inside {SLEW_ADDR, SRC_ADDR, STATUS3_ADDR, BOOT_ADDR};
    // Settle count: the strap and clock samplers need a few edges
    always_comb begin
        run_d = srst ? 3'h0 : ((run_q == 3'h7) ? run_q : run_q + 3'h1);
    end
    // Settle count register
    always_ff @(posedge ref_clk) begin
        run_q <= run_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_ack_next_cycle: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged next cycle");
    a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    a_reset_state: assert property ($fell(srst) |-> !debug_clock_output_oe_n && output_slew_rate == 16'h0 && !pll_bypass)
        else $error("output not enabled after reset");
    a_gen_from_osc: assert property (run_q == 3'h7 && !clock_select_pin |-> generator_clk_src == $past(rtc_osc_clk, 3))
        else $error("generator not fed by oscillator");
    a_gen_from_ref: assert property (run_q == 3'h7 && clock_select_pin
        |-> generator_clk_src == $past(external_reference_clock_input, 3))
        else $error("generator not fed by reference");
    a_rtc_from_osc: assert property (run_q == 3'h7 |-> rtc_timer_clk == $past(rtc_osc_clk, 3))
        else $error("timer not fed by oscillator");
    a_bypass_strap: assert property (pll_bypass |-> clock_select_pin)
        else $error("bypass without external reference");
    a_boot_dividers: assert property (spi_clk_div != 16'h0
        |-> spi_clk_div inside {16'h17, 16'h18, 16'h19} && i2c_clk_div == spi_clk_div + 16'h6)
        else $error("boot serial dividers off target");
endmodule
bind clock_source_select_and_debug_clock_output_pin clk_ctrl_checker clk_ctrl_checker_inst (
    .ref_clk(ref_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .clock_select_pin(clock_select_pin),
    .external_reference_clock_input(external_reference_clock_input), .rtc_osc_clk(rtc_osc_clk),
    .generator_clk_src(generator_clk_src), .rtc_timer_clk(rtc_timer_clk),
    .debug_clock_output_oe_n(debug_clock_output_oe_n), .output_slew_rate(output_slew_rate),
    .pll_bypass(pll_bypass), .spi_clk_div(spi_clk_div), .i2c_clk_div(i2c_clk_div));

// ==== tb/board_clock_source.sv ====
// Board model: select strap, external reference and 32-kHz oscillator
`timescale 1ns/1ns
module board_clock_source (
    input  wire logic strap_high,
    output logic      clock_select_pin,
    output logic      external_reference_clock_input,
    output logic      rtc_osc_clk
);
    logic ref_run;  // Free-running reference oscillator
    // Oscillators off the bus clock grid, so no rising edge meets it
    initial begin
        ref_run = 1'b0;
        rtc_osc_clk = 1'b0;
        fork
            forever #30 ref_run = ~ref_run;
            forever #50 rtc_osc_clk = ~rtc_osc_clk;
        join
    end
    assign clock_select_pin = strap_high;
    assign external_reference_clock_input = strap_high ? ref_run : 1'b0;
endmodule

// ==== tb/test_clock_source_select_and_debug_clock_output_pin.sv ====
// Self-checking bench for clock source select and debug clock output
`timescale 1ns/1ns
module test_clock_source_select_and_debug_clock_output_pin;
    import clk_ctrl_pkg::*;
    logic        ref_clk = 1'b0, srst = 1'b1, strap_high = 1'b1;
    logic [15:0] wb_adr_i = 16'h0, output_slew_rate, spi_clk_div, i2c_clk_div;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, wb_err_o;
    logic        boot_start = 1'b0, sys_clk_tap = 1'b0, pll_clk_tap = 1'b0;
    logic [1:0]  ref_freq_code = 2'h0;
    logic        clock_select_pin, external_reference_clock_input, rtc_osc_clk, generator_clk_src;
    logic        rtc_timer_clk, debug_clock_output_pin, debug_clock_output_oe_n, pll_bypass;
    logic [3:0]  h1, h2, h3;                 // Tap input history, one edge per stage
    logic        g0;                         // Generator source, one edge later as it passes a register
    int          err_total = 0, num_checks = 0;
    // Clocks: bus 10 ns, debug taps on even times off its rising edges
    always #5 ref_clk = ~ref_clk;
    always #20 sys_clk_tap = ~sys_clk_tap;
    always #30 pll_clk_tap = ~pll_clk_tap;
    // Tap inputs ordered by select code, delayed as the pin is
    always @(posedge ref_clk) begin
        g0 <= strap_high ? external_reference_clock_input : rtc_osc_clk;
        h1 <= {pll_clk_tap, rtc_osc_clk, g0, sys_clk_tap};
        h2 <= h1;
        h3 <= h2;
    end
    board_clock_source board_clock_source_inst (.strap_high(strap_high), .clock_select_pin(clock_select_pin),
        .external_reference_clock_input(external_reference_clock_input), .rtc_osc_clk(rtc_osc_clk));
    clock_source_select_and_debug_clock_output_pin clock_source_select_and_debug_clock_output_pin_inst (.ref_clk(ref_clk), .srst(srst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'h3),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .clock_select_pin(clock_select_pin), .external_reference_clock_input(external_reference_clock_input),
        .rtc_osc_clk(rtc_osc_clk), .sys_clk_tap(sys_clk_tap), .pll_clk_tap(pll_clk_tap),
        .boot_start(boot_start), .ref_freq_code(ref_freq_code), .generator_clk_src(generator_clk_src),
        .rtc_timer_clk(rtc_timer_clk), .debug_clock_output_pin(debug_clock_output_pin),
        .debug_clock_output_oe_n(debug_clock_output_oe_n), .output_slew_rate(output_slew_rate),
        .pll_bypass(pll_bypass), .spi_clk_div(spi_clk_div), .i2c_clk_div(i2c_clk_div));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack or err is sampled
    task automatic wb(input logic [15:0] a, input logic we, input logic [31:0] d,
                      output logic [31:0] q, output logic er);
        int n;
        @(posedge ref_clk);
        {wb_adr_i, wb_we_i, wb_dat_i} <= {a, we, d};
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        er = wb_err_o;
        if (n == 50) check(32'h1, 32'h0);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // Reset with the strap set while the device is held
    task automatic do_reset(input logic strap);
        @(posedge ref_clk);
        {srst, strap_high, boot_start} <= {1'b1, strap, 1'b0};
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    // Reset values, slew register, refused address
    task automatic t_regs;
        logic [31:0] q;
        logic        er;
        check(32'(debug_clock_output_oe_n), 32'h0);
        wb(SRC_ADDR, 1'b0, 32'h0, q, er);
        check(q, 32'(TAP_RESET));
        wb(SLEW_ADDR, 1'b1, 32'hffff_a5c3, q, er);
        wb(SLEW_ADDR, 1'b0, 32'h0, q, er);
        check(q, 32'h0000_a5c3);
        check(32'(output_slew_rate), 32'ha5c3);
        wb(16'h7000, 1'b1, 32'h1, q, er);
        check(32'(er), 32'h1);
        $display("test registers done");
    endtask
    // Every tap code routed to the pin
    task automatic t_taps;
        logic [31:0] q;
        logic        er;
        int          bad;
        for (int t = 0; t < 4; t++) begin
            wb(SRC_ADDR, 1'b1, 32'(t), q, er);
            repeat (4) @(posedge ref_clk);
            bad = 0;
            repeat (40) begin
                @(posedge ref_clk);
                #1;
                if (debug_clock_output_pin !== h3[t]) bad++;
            end
            check(32'(bad), 32'h0);
        end
        $display("test taps done");
    endtask
    // Clock-off bit gates the pin both ways
    task automatic t_gate;
        logic [31:0] q;
        logic        er;
        wb(STATUS3_ADDR, 1'b1, 32'h4, q, er);
        repeat (3) @(posedge ref_clk);
        check(32'(debug_clock_output_oe_n), 32'h1);
        wb(STATUS3_ADDR, 1'b1, 32'h0, q, er);
        repeat (3) @(posedge ref_clk);
        check(32'(debug_clock_output_oe_n), 32'h0);
        $display("test gate done");
    endtask
    // Boot: pin released, bypass and serial dividers set
    task automatic t_boot(input logic strap, input logic [1:0] code, input logic [15:0] spi, input logic [15:0] i2c);
        logic [31:0] q;
        logic        er;
        do_reset(strap);
        ref_freq_code <= code;
        check(32'(debug_clock_output_oe_n), 32'h0);
        boot_start <= 1'b1;
        @(posedge ref_clk);
        boot_start <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check(32'(debug_clock_output_oe_n), 32'h1);
        check(32'(pll_bypass), 32'(strap));
        check({spi_clk_div, i2c_clk_div}, {spi, i2c});
        wb(BOOT_ADDR, 1'b0, 32'h0, q, er);
        check(q & 32'h13, {27'h0, 1'b1, 2'h0, strap, strap});
        $display("test boot done");
    endtask
    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset(1'b1);
        t_regs();
        t_taps();
        t_gate();
        t_boot(1'b1, 2'h0, 16'h17, 16'h1d);
        t_boot(1'b1, 2'h1, 16'h18, 16'h1e);
        t_boot(1'b1, 2'h2, 16'h19, 16'h1f);
        t_boot(1'b0, 2'h0, 16'h18, 16'h1e);
        do_reset(1'b0);
        t_taps();
        final_report();
    end
    // Watchdog against a hung handshake
    initial begin
        #300000;
        err_total++;
        final_report();
    end
endmodule
